// ==== inc/ppmc_consts.svh ====
// Purpose: constants for the power-management capability register block
// Assumes: byte addresses are configuration-space offsets of this function
// Notes: included by its bare name; definitions only
`ifndef PPMC_CONSTS_SVH
`define PPMC_CONSTS_SVH

// ****************************************************************
// register offsets (byte addresses in configuration space)
// ****************************************************************
`define PPMC_CAP_ID_OFS 8'hA0
`define PPMC_LINK_OFS 8'hA1
`define PPMC_FEAT_OFS 8'hA2

// ****************************************************************
// fixed values and reset values
// ****************************************************************
`define PPMC_CAP_ID_VAL 8'h01
`define PPMC_LINK_VAL 8'h00
`define PPMC_FEAT_RST 16'hFE21
`define PPMC_D3COLD_RST 1'h1
`define PPMC_WAKE_FIXED 4'hF
`define PPMC_RSVD_VAL 3'h0
`define PPMC_VERSION_VAL 3'h1
`define PPMC_AUX_RST 1'h0

// ****************************************************************
// field positions inside the feature word
// ****************************************************************
`define PPMC_D3COLD_BIT 15
`define PPMC_WAKE_HI 15
`define PPMC_WAKE_LO 11
`define PPMC_DEEP_BIT 10
`define PPMC_LIGHT_BIT 9
`define PPMC_RSVD_HI 8
`define PPMC_RSVD_LO 6
`define PPMC_DSI_BIT 5
`define PPMC_AUX_BIT 4
`define PPMC_CLK_BIT 3
`define PPMC_VER_HI 2
`define PPMC_VER_LO 0

`endif

// ==== inc/ppmc_pkg.sv ====
// Purpose: types shared by the power-management capability register block
// Assumes: nothing beyond the constants header
// Notes: power-state order matches the two-bit state field encoding
`default_nettype none

package ppmc_pkg;

   // ****************************************************************
   // power states as encoded by the control/status state field
   // ****************************************************************
   typedef enum logic [1:0] {
      PPMC_D0,
      PPMC_D1,
      PPMC_D2,
      PPMC_D3HOT
   } ppmc_pstate_e;

   typedef logic [31:0] ppmc_word_t;
   typedef logic [15:0] ppmc_feat_t;

endpackage

`default_nettype wire

// ==== rtl/ppmc_regs.sv ====
// Purpose: pm_capability_identifier, list link and feature word of the power-management entry
// Assumes: one configuration access per request cycle, inputs synchronous to ref_clk_in
// Notes: the whole dword at A0h is returned on a read; only bit 31 of it is writable
//
// Contract
// - The capability identifier byte always reads 01h and ignores writes.
// - The next-item pointer byte always reads 00h because the list ends here.
// - The five-bit wake-support field reads 11111b after reset.
// - A zero wake-support bit stops the wake signal in the matching power state.
// - Bit 15 (wake from D3cold) resets to 1 and is host-writable; firmware clears it.
// - Bits 14 to 11 are read-only ones for D3hot, D2, D1 and D0 wake capability.
// - Bit 10 is a read-only one reporting Deep_doze_supported.
// - Bit 9 is a read-only one reporting Light_doze_supported.
// - Bits 8 to 6 are reserved and always read zero.
// - Bit 5 reads one to flag that device-specific initialization is needed.
// - Bit 4, the auxiliary-power flag, is read-only and defaults to zero.
// - Bit 3 reads zero because no bus clock is needed to raise the wake signal.
// - Bits 2 to 0 read 001b for four bytes of general power-management registers.
// - The power-state field codes 00 D0, 01 D1, 10 D2 and 11 D3hot.
`include "ppmc_consts.svh"
`default_nettype none

module ppmc_regs
   import ppmc_pkg::*;
#(
   parameter logic AUX_SUPPLY_FLAG = `PPMC_AUX_RST
)
(
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic cfg_rd_in,
   input wire logic cfg_wr_in,
   input wire logic [7:0] cfg_addr_in,
   input wire logic [3:0] cfg_byte_en_in,
   input wire logic [31:0] cfg_wdata_in,
   input wire logic [1:0] power_state_field_in,
   input wire logic in_d3cold_in,
   input wire logic wake_event_in,
   output logic [31:0] cfg_rdata_out,
   output logic cfg_ack_out,
   output logic wake_out,
   output logic [4:0] wake_state_mask_out
);

   // ****************************************************************
   // helper functions
   // ****************************************************************

   // true when a byte address falls in the dword holding this entry
   function automatic logic ppmc_dword_hit(input logic [7:0] addr);
      // the dword index is six bits wide, so the shifted offset is cut to match
      ppmc_dword_hit = (addr[7:2] == 6'(`PPMC_CAP_ID_OFS >> 2));
   endfunction

   // picks the wake-support bit for the present power state
   function automatic logic ppmc_wake_allowed(input logic [4:0] mask,
                                              input ppmc_pstate_e state,
                                              input logic cold);
      logic pick;
      pick = 1'b0;
      if (cold)
      begin
         pick = mask[4];
      end
      else
      begin
         case (state)
            PPMC_D0: pick = mask[0];
            PPMC_D1: pick = mask[1];
            PPMC_D2: pick = mask[2];
            PPMC_D3HOT: pick = mask[3];
            default: pick = 1'b0;
         endcase
      end
      ppmc_wake_allowed = pick;
   endfunction

   // ****************************************************************
   // state and decode
   // ****************************************************************
   logic d3cold_wake_r;
   logic d3cold_wake_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic ack_r;
   logic wake_r;
   logic wake_nxt;
   wire logic hit;
   wire logic wr_hit;
   wire logic d3cold_wr;
   wire ppmc_pstate_e cur_state;
   wire ppmc_feat_t feat_word;
   wire logic [31:0] entry_dword;
   wire logic [4:0] wake_state_mask;
   wire logic deep_doze_supported;
   wire logic light_doze_supported;
   wire logic aux_supply_flag;
   wire logic wake_clock_needed;

   // address decode for the single mapped dword
   assign hit = ppmc_dword_hit(cfg_addr_in);
   assign wr_hit = cfg_wr_in && hit;
   // only the top byte lane carries the one writable bit
   assign d3cold_wr = wr_hit && cfg_byte_en_in[3];

   // fixed capability flags
   assign deep_doze_supported = 1'b1;
   assign light_doze_supported = 1'b1;
   assign aux_supply_flag = AUX_SUPPLY_FLAG;
   assign wake_clock_needed = 1'b0;

   // wake mask: writable D3cold bit above four hardwired ones
   assign wake_state_mask = {d3cold_wake_r, `PPMC_WAKE_FIXED};

   // feature word assembled from its fields; read-only parts are constants
   assign feat_word = {wake_state_mask,
                       deep_doze_supported,
                       light_doze_supported,
                       `PPMC_RSVD_VAL,
                       1'b1,
                       aux_supply_flag,
                       wake_clock_needed,
                       `PPMC_VERSION_VAL};

   // identifier and list link are constants so writes cannot touch them
   assign entry_dword = {feat_word, `PPMC_LINK_VAL, `PPMC_CAP_ID_VAL};

   // unmapped dwords read as zero so the host sees a harmless value
   assign rdata_nxt = (cfg_rd_in && hit) ? entry_dword : rdata_r;

   // ****************************************************************
   // writable D3cold wake bit
   // ****************************************************************

   // firmware clears this when no auxiliary supply backs D3cold wake
   assign d3cold_wake_nxt = d3cold_wr ? cfg_wdata_in[31] : d3cold_wake_r;

   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         d3cold_wake_r <= `PPMC_D3COLD_RST;
      end
      else
      begin
         d3cold_wake_r <= d3cold_wake_nxt;
      end
   end

   // ****************************************************************
   // configuration read path and acknowledge
   // ****************************************************************

   // read data is held until the next read so a slow host can sample it
   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         rdata_r <= 32'h0000_0000;
         ack_r <= 1'b0;
      end
      else
      begin
         if (cfg_rd_in && !hit)
         begin
            rdata_r <= 32'h0000_0000;
         end
         else
         begin
            rdata_r <= rdata_nxt;
         end
         ack_r <= cfg_rd_in || cfg_wr_in;
      end
   end

   // ****************************************************************
   // wake gating by power state
   // ****************************************************************

   // the state field order gives D0..D3hot; D3cold comes from a separate flag
   assign cur_state = ppmc_pstate_e'(power_state_field_in);
   assign wake_nxt = wake_event_in &&
                     ppmc_wake_allowed(wake_state_mask, cur_state, in_d3cold_in);

   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         wake_r <= 1'b0;
      end
      else
      begin
         wake_r <= wake_nxt;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign cfg_rdata_out = rdata_r;
   assign cfg_ack_out = ack_r;
   assign wake_out = wake_r;
   assign wake_state_mask_out = wake_state_mask;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking ppmc_cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!resetn_in);

   cap_id_read_a: assert property ((cfg_rd_in && hit) |=>
      cfg_rdata_out[7:0] == 8'h01)
      else $error("pm_capability_identifier did not read 01h");

   link_read_a: assert property ((cfg_rd_in && hit) |=>
      cfg_rdata_out[15:8] == 8'h00)
      else $error("list link did not read zero");

   wake_fixed_ones_a: assert property ((cfg_rd_in && hit) |=>
      cfg_rdata_out[30:27] == 4'hF)
      else $error("fixed wake bits not all ones");

   doze_flags_a: assert property ((cfg_rd_in && hit) |=>
      cfg_rdata_out[26] && cfg_rdata_out[25])
      else $error("doze support flags not set");

   rsvd_low_fields_a: assert property ((cfg_rd_in && hit) |=>
      cfg_rdata_out[24:22] == 3'h0 && cfg_rdata_out[21] && !cfg_rdata_out[19])
      else $error("reserved, init or clock bits wrong");

   version_field_a: assert property ((cfg_rd_in && hit) |=>
      cfg_rdata_out[18:16] == 3'h1 && cfg_rdata_out[20] == AUX_SUPPLY_FLAG)
      else $error("version or aux flag wrong");

   d3cold_write_a: assert property ((cfg_wr_in && hit && cfg_byte_en_in[3]) |=>
      d3cold_wake_r == $past(cfg_wdata_in[31]))
      else $error("d3cold wake bit did not take written value");

   d3cold_hold_a: assert property (!(cfg_wr_in && hit && cfg_byte_en_in[3]) |=>
      $stable(d3cold_wake_r))
      else $error("d3cold wake bit changed without a write");

   readback_write_a: assert property ((cfg_wr_in && hit && cfg_byte_en_in[3])
      ##1 (cfg_rd_in && hit && !cfg_wr_in) |=>
      cfg_rdata_out[31] == $past(cfg_wdata_in[31], 2) &&
      cfg_rdata_out[30:0] == 31'h7E21_0001)
      else $error("read-back after write wrong");

   wake_gate_a: assert property ((wake_event_in && in_d3cold_in && !d3cold_wake_r) |=>
      !wake_out)
      else $error("wake raised from a state without support");

   wake_pass_a: assert property ((wake_event_in && !in_d3cold_in) |=>
      wake_out)
      else $error("wake lost in a supported hot state");

   ack_timing_a: assert property ((cfg_rd_in || cfg_wr_in) |=> cfg_ack_out ##1
      (cfg_ack_out == $past(cfg_rd_in || cfg_wr_in)))
      else $error("acknowledge not one cycle after request");

   reset_value_a: assert property (@(posedge ref_clk_in) disable iff (1'b0)
      !resetn_in |=> d3cold_wake_r && !wake_out && !cfg_ack_out)
      else $error("reset values wrong");

   // read-back and acknowledge: the writable bit, unmapped dwords, held data and no ack when idle
   read_cold_bit_a: assert property ((cfg_rd_in && hit) |=>
      cfg_rdata_out[31] == $past(d3cold_wake_r))
      else $error("d3cold wake bit read-back wrong");

   unmapped_read_a: assert property ((cfg_rd_in && !hit) |=>
      cfg_rdata_out == 32'h0000_0000)
      else $error("unmapped read did not return zero");

   rdata_hold_a: assert property (!cfg_rd_in |=>
      $stable(cfg_rdata_out))
      else $error("read data changed without a read");

   ack_idle_a: assert property (!(cfg_rd_in || cfg_wr_in) |=>
      !cfg_ack_out)
      else $error("acknowledge without a request");

   // wake gating: no event means no wake, and a set D3cold bit lets it through
   wake_idle_a: assert property (!wake_event_in |=>
      !wake_out)
      else $error("wake raised with no wake event");

   wake_cold_pass_a: assert property ((wake_event_in && in_d3cold_in && d3cold_wake_r) |=>
      wake_out)
      else $error("wake lost in D3cold with support set");

   // ****************************************************************
   // covers
   // ****************************************************************
   read_entry_c: cover property (cfg_rd_in && hit ##1 cfg_ack_out);
   clear_cold_c: cover property (d3cold_wr && !cfg_wdata_in[31] ##1 !d3cold_wake_r);
   wake_d3hot_c: cover property (wake_event_in && cur_state == PPMC_D3HOT ##1 wake_out);
   unmapped_rd_c: cover property (cfg_rd_in && !hit ##1 cfg_ack_out);
   cold_blocked_c: cover property (wake_event_in && in_d3cold_in && !d3cold_wake_r ##1 !wake_out);

endmodule

`default_nettype wire

// ==== tb/pci_power_mgmt_capability_regs_tb.sv ====
// Purpose: self-checking bench for the power-management capability registers
// Assumes: ack and read data one cycle after the request, wake gated one cycle late
// Notes: a small reference model tracks the only writable bit
`default_nettype none

module pci_power_mgmt_capability_regs_tb;
   import ppmc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk_in = 1'h0;
   logic resetn_in = 1'h0;
   logic cfg_rd, cfg_wr, cfg_ack_out, wake_out, d3c_m, rd, wr;
   logic [7:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata_out;
   logic [4:0] wake_state_mask_out;
   logic [1:0] ps_in = 2'h0;
   logic cold_in = 1'h0;
   logic ev_in = 1'h0;
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;

   initial
   begin
      forever #20 ref_clk_in = ~ref_clk_in;
   end

   ppmc_regs u_ppmc_regs (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .cfg_rd_in(cfg_rd), .cfg_wr_in(cfg_wr), .cfg_addr_in(cfg_addr),
      .cfg_byte_en_in(cfg_be), .cfg_wdata_in(cfg_wdata), .power_state_field_in(ps_in),
      .in_d3cold_in(cold_in), .wake_event_in(ev_in), .cfg_rdata_out(cfg_rdata_out),
      .cfg_ack_out(cfg_ack_out), .wake_out(wake_out),
      .wake_state_mask_out(wake_state_mask_out));

   ppmc_host_model u_ppmc_host_model (.ref_clk_in(ref_clk_in), .cfg_rd_out(cfg_rd),
      .cfg_wr_out(cfg_wr), .cfg_addr_out(cfg_addr), .cfg_byte_en_out(cfg_be),
      .cfg_wdata_out(cfg_wdata));

   // ****************************************************************
   // reference model and checking helpers
   // ****************************************************************
   // unmapped reads answer zero, so the decode is part of the model
   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      if (a[7:2] != 6'h28)
      begin
         return 32'h0;
      end
      return {d3c_m, 4'hF, 11'h621, 16'h0001};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // expected read value is taken before the write lands: same-cycle read sees old data
   task automatic op(input logic rd, input logic wr, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] d);
      logic [31:0] e;
      e = exp_rd(a);
      u_ppmc_host_model.access(rd, wr, a, be, d);
      chk({31'h0, cfg_ack_out}, 32'h1);
      if (rd)
      begin
         chk(cfg_rdata_out, e);
      end
      if (wr && a[7:2] == 6'h28 && be[3])
      begin
         d3c_m = d[31];
      end
      chk({27'h0, wake_state_mask_out}, {27'h0, d3c_m, 4'hF});
   endtask

   task automatic wk(input logic [1:0] ps, input logic cold, input logic ev);
      @(posedge ref_clk_in);
      #1;
      ps_in = ps;
      cold_in = cold;
      ev_in = ev;
      @(posedge ref_clk_in);
      #1;
      chk({31'h0, wake_out}, {31'h0, ev & (cold ? d3c_m : 1'h1)});
   endtask

   task automatic do_reset();
      @(posedge ref_clk_in);
      #1;
      resetn_in = 1'h0;
      repeat (3) @(posedge ref_clk_in);
      #1;
      resetn_in = 1'h1;
      d3c_m = 1'h1;
   endtask

   task automatic tally_and_finish();
      if (bad_count == 0 && checked > 0)
      begin
         $display("Run complete: PASS");
      end
      else
      begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge ref_clk_in)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         bad_count++;
         tally_and_finish();
      end
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      void'($urandom(17));
      d3c_m = 1'h1;
      repeat (3) @(posedge ref_clk_in);
      #1;
      resetn_in = 1'h1;
      op(1'h1, 1'h0, 8'hA0, 4'h0, 32'h0);
      op(1'h0, 1'h1, 8'hA0, 4'h7, 32'h0);
      op(1'h1, 1'h0, 8'hA2, 4'h0, 32'h0);
      op(1'h0, 1'h1, 8'hA4, 4'hF, 32'h0);
      op(1'h1, 1'h1, 8'hA3, 4'h8, 32'h0);
      op(1'h1, 1'h0, 8'hA1, 4'h0, 32'h0);
      // first half runs with the D3cold bit clear, second half with it set
      for (int i = 0; i < 32; i++)
      begin
         wk(2'(i), i[2], i[3]);
         if (i == 15)
         begin
            op(1'h0, 1'h1, 8'hA0, 4'h8, 32'h8000_0000);
         end
      end
      op(1'h0, 1'h1, 8'hA0, 4'hF, 32'h0);
      for (int i = 0; i < 40; i++)
      begin
         rd = 1'($urandom);
         wr = ~rd | 1'($urandom);
         op(rd, wr, 8'h9E + 8'($urandom_range(7, 0)), 4'($urandom), $urandom);
      end
      u_ppmc_host_model.wr_then_rd(8'hA0, 4'h8, 32'h0);
      d3c_m = 1'h0;
      chk({31'h0, cfg_ack_out}, 32'h1);
      chk(cfg_rdata_out, exp_rd(8'hA0));
      u_ppmc_host_model.wr_then_rd(8'hA2, 4'hF, 32'hFFFF_FFFF);
      d3c_m = 1'h1;
      chk(cfg_rdata_out, exp_rd(8'hA2));
      op(1'h0, 1'h1, 8'hA0, 4'h8, 32'h0);
      do_reset();
      op(1'h1, 1'h0, 8'hA0, 4'h0, 32'h0);
      op(1'h1, 1'h0, 8'h9C, 4'h0, 32'h0);
      tally_and_finish();
   end
endmodule

`default_nettype wire

// ==== tb/ppmc_host_model.sv ====
// Purpose: host-side model issuing configuration reads and writes
// Assumes: one access per request pulse, answered one cycle later
// Notes: released address, enables and data show inverted values, never the old ones
`default_nettype none

module ppmc_host_model
(
   input wire logic ref_clk_in,
   output logic cfg_rd_out,
   output logic cfg_wr_out,
   output logic [7:0] cfg_addr_out,
   output logic [3:0] cfg_byte_en_out,
   output logic [31:0] cfg_wdata_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // idle bus at time zero
   // ****************************************************************
   initial
   begin
      cfg_rd_out = 1'h0;
      cfg_wr_out = 1'h0;
      cfg_addr_out = 8'h00;
      cfg_byte_en_out = 4'h0;
      cfg_wdata_out = 32'h0;
   end

   // one-cycle request; firmware may clear the wake-from-cold bit through wdata bit 31
   task automatic access(input logic rd, input logic wr, input logic [7:0] a,
                         input logic [3:0] be, input logic [31:0] d);
      @(posedge ref_clk_in);
      #1;
      cfg_rd_out = rd;
      cfg_wr_out = wr;
      cfg_addr_out = a;
      cfg_byte_en_out = be;
      cfg_wdata_out = d;
      @(posedge ref_clk_in);
      #1;
      cfg_rd_out = 1'h0;
      cfg_wr_out = 1'h0;
      // inverted so a design sampling stale qualifiers shows a wrong value
      cfg_addr_out = ~a;
      cfg_byte_en_out = ~be;
      cfg_wdata_out = ~d;
   endtask

   // write then read of the same address in consecutive cycles, the tightest order allowed
   task automatic wr_then_rd(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge ref_clk_in);
      #1;
      cfg_wr_out = 1'h1;
      cfg_addr_out = a;
      cfg_byte_en_out = be;
      cfg_wdata_out = d;
      @(posedge ref_clk_in);
      #1;
      cfg_wr_out = 1'h0;
      cfg_rd_out = 1'h1;
      cfg_wdata_out = ~d;
      @(posedge ref_clk_in);
      #1;
      cfg_rd_out = 1'h0;
      cfg_addr_out = ~a;
      cfg_byte_en_out = ~be;
   endtask
endmodule

`default_nettype wire
